// ===== core/sirp_port.sv
// Serial register port: SPI or I2C slave to a 64 x 24 register map
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - Latch select level at cold start; low means SPI, high means I2C.
// - Weak pull-down on select, switched off once I2C mode is latched.
// - SPI frame: write flag, 6 address bits, null bit, 24 data bits.
// - Address picks one of 64 locations, 24 bits each, all addressable.
// - Flag, address and null bit sampled on rising SPI clock edges.
// - Register data driven on MISO, changed on falling clock edges.
// - Read frames ignore later bits and leave the register unchanged.
// - Write frame commits 24 data bits on the 32nd falling edge.
// - Write frame also shifts out current data of the same register.
// - Select active high; early drop before 32nd fall aborts the frame.
// - In SPI mode, MISO is released whenever select is low.
// - Read-back returns zeros in the address field positions.
// - I2C uses clock pin as SCL, MISO as open-drain SDA; slave only.
// - I2C answers only to address 000100 plus strapped MOSI bit.
// - I2C follows Fast Mode, up to 400 kbit/s.
// - I2C write is three bytes, MSB first; commit on third ACK.
// - I2C write ended before three bytes is dropped.
// - I2C read sends three bytes MSB first; stops on STOP or NACK.
module sirp_port (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic nrst,
  // Cold start init phase, high while the mode latch is open
  input  wire logic init_phase,
  // Pins
  input  wire logic sel_pin,
  input  wire logic clk_pin,
  input  wire logic mosi_pin,
  input  wire logic miso_in,
  output logic      miso_out,
  output logic      miso_oe_n,
  output logic      sel_pulldown_en,
  // Mode status
  output logic      bus_mode_select_latch
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  sirp_pkg::sirp_pins_s meta_q;
  sirp_pkg::sirp_pins_s sync_q;
  sirp_pkg::sirp_pins_s prev_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= {clk_pin, sel_pin, mosi_pin, miso_in};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  logic clk_rise;
  logic clk_fall;
  logic sel_hi;
  // Some fifty samples per fast-mode bit, so no edge is missed
  assign clk_rise = sync_q.clk & ~prev_q.clk;
  assign clk_fall = ~sync_q.clk & prev_q.clk;
  assign sel_hi   = sync_q.sel;

  // ****************************************
  // Mode latch
  // ****************************************
  logic init_d1_q;
  logic mode_i2c_q;
  logic strap_a0_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      init_d1_q  <= 1'b0;
      mode_i2c_q <= 1'b0;
      strap_a0_q <= 1'b0;
    end else begin
      init_d1_q <= init_phase;
      if (init_phase) begin
        mode_i2c_q <= sync_q.sel;
        strap_a0_q <= sync_q.mosi;
      end
    end
  end

  assign bus_mode_select_latch = mode_i2c_q;
  assign sel_pulldown_en       = ~mode_i2c_q;

  // ****************************************
  // Register map
  // ****************************************
  // Unpopulated locations are plain storage so every address answers
  logic [23:0] regs_q [sirp_pkg::REG_COUNT];
  logic        wr_en;
  logic [5:0]  wr_addr;
  logic [23:0] wr_data;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < sirp_pkg::REG_COUNT; i++) begin
        regs_q[i] <= sirp_pkg::REG_RST_VAL;
      end
    end else if (wr_en) begin
      regs_q[wr_addr] <= wr_data;
    end
  end

  // ****************************************
  // SPI engine
  // ****************************************
  logic [5:0]  spi_cnt_q;
  logic [7:0]  spi_hdr_q;
  logic [23:0] spi_sh_q;
  logic [23:0] spi_out_q;
  logic        spi_miso_q;
  logic        spi_wr;
  logic        spi_mode;

  assign spi_mode = ~mode_i2c_q;
  assign spi_wr   = spi_mode & sel_hi & clk_fall & (spi_cnt_q == sirp_pkg::SPI_LAST_BIT)
                    & spi_hdr_q[7];

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      spi_cnt_q <= '0;
      spi_hdr_q <= '0;
      spi_sh_q  <= '0;
    end else if (!spi_mode || !sel_hi) begin
      spi_cnt_q <= '0;
    end else begin
      if (clk_rise) begin
        if (spi_cnt_q <= sirp_pkg::SPI_LAST_HDR) begin
          spi_hdr_q <= {spi_hdr_q[6:0], sync_q.mosi};
        end else begin
          spi_sh_q <= {spi_sh_q[22:0], sync_q.mosi};
        end
      end
      if (clk_fall && spi_cnt_q != sirp_pkg::SPI_LAST_BIT) begin
        spi_cnt_q <= spi_cnt_q + 6'h01;
      end
    end
  end

  // Outgoing data loads after the null bit is in, shifting on falls
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      spi_out_q  <= '0;
      spi_miso_q <= 1'b0;
    end else if (!sel_hi) begin
      spi_miso_q <= 1'b0;
    end else if (clk_fall) begin
      if (spi_cnt_q == sirp_pkg::SPI_LAST_HDR) begin
        spi_out_q  <= {regs_q[spi_hdr_q[6:1]][22:0], 1'b0};
        spi_miso_q <= regs_q[spi_hdr_q[6:1]][23];
      end else if (spi_cnt_q > sirp_pkg::SPI_LAST_HDR) begin
        spi_miso_q <= spi_out_q[23];
        spi_out_q  <= {spi_out_q[22:0], 1'b0};
      end else begin
        spi_miso_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // I2C engine
  // ****************************************
  sirp_pkg::sirp_i2c_e st_q;
  logic [3:0]  bit_q;
  logic [7:0]  byte_q;
  logic [1:0]  bcnt_q;
  logic        rnw_q;
  logic [5:0]  raddr_q;
  logic [23:0] wbuf_q;
  logic [23:0] rbuf_q;
  logic        sda_low_q;
  logic        reg_seen_q;
  logic        i2c_start;
  logic        i2c_stop;
  logic        i2c_wr;

  // Start and stop are data edges while SCL is high
  assign i2c_start = mode_i2c_q & sync_q.clk & prev_q.clk & prev_q.sda & ~sync_q.sda;
  assign i2c_stop  = mode_i2c_q & sync_q.clk & prev_q.clk & ~prev_q.sda & sync_q.sda;
  // Commit only when the third data byte is acknowledged
  assign i2c_wr = (st_q == sirp_pkg::I2C_DACK) & clk_fall & bcnt_q == 2'd3 & ~rnw_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q      <= sirp_pkg::I2C_IDLE;
      bit_q     <= '0;
      byte_q    <= '0;
      bcnt_q    <= '0;
      rnw_q     <= 1'b0;
      raddr_q   <= '0;
      wbuf_q    <= '0;
      rbuf_q    <= '0;
      sda_low_q <= 1'b0;
      reg_seen_q <= 1'b0;
    end else if (!mode_i2c_q || i2c_stop) begin
      st_q      <= sirp_pkg::I2C_IDLE;
      sda_low_q <= 1'b0;
    end else if (i2c_start) begin
      st_q      <= sirp_pkg::I2C_DEV;
      bit_q     <= '0;
      bcnt_q    <= '0;
      sda_low_q <= 1'b0;
      reg_seen_q <= 1'b0;
    end else begin
      unique case (st_q)
        sirp_pkg::I2C_IDLE, sirp_pkg::I2C_SKIP: begin
          sda_low_q <= 1'b0;
        end
        sirp_pkg::I2C_DEV, sirp_pkg::I2C_REG, sirp_pkg::I2C_WDAT: begin
          if (clk_rise) begin
            byte_q <= {byte_q[6:0], sync_q.sda};
            bit_q  <= bit_q + 4'd1;
          end
          if (clk_fall && bit_q == 4'd8) begin
            bit_q <= '0;
            if (st_q == sirp_pkg::I2C_DEV) begin
              if (byte_q[7:1] == {sirp_pkg::I2C_ADDR_HI, strap_a0_q}) begin
                rnw_q     <= byte_q[0];
                sda_low_q <= 1'b1;
                st_q      <= sirp_pkg::I2C_DACK;
              end else begin
                st_q <= sirp_pkg::I2C_SKIP;
              end
            end else if (st_q == sirp_pkg::I2C_REG) begin
              raddr_q   <= byte_q[5:0];
              reg_seen_q <= 1'b1;
              sda_low_q <= 1'b1;
              st_q      <= sirp_pkg::I2C_DACK;
            end else begin
              wbuf_q    <= {wbuf_q[15:0], byte_q};
              bcnt_q    <= bcnt_q + 2'd1;
              sda_low_q <= 1'b1;
              st_q      <= sirp_pkg::I2C_DACK;
            end
          end
        end
        sirp_pkg::I2C_DACK: begin
          if (clk_fall) begin
            sda_low_q <= 1'b0;
            if (rnw_q) begin
              rbuf_q    <= {regs_q[raddr_q][22:0], 1'b0};
              sda_low_q <= ~regs_q[raddr_q][23];
              bit_q     <= 4'd1;
              bcnt_q    <= 2'd1;
              st_q      <= sirp_pkg::I2C_RDAT;
            end else if (!reg_seen_q) begin
              st_q <= sirp_pkg::I2C_REG;
            end else if (bcnt_q == 2'd3) begin
              st_q <= sirp_pkg::I2C_SKIP;
            end else begin
              st_q <= sirp_pkg::I2C_WDAT;
            end
          end
        end
        sirp_pkg::I2C_RDAT: begin
          if (clk_fall) begin
            if (bit_q == 4'd8) begin
              sda_low_q <= 1'b0;
              bit_q     <= '0;
              st_q      <= sirp_pkg::I2C_MACK;
            end else begin
              sda_low_q <= ~rbuf_q[23];
              rbuf_q    <= {rbuf_q[22:0], 1'b0};
              bit_q     <= bit_q + 4'd1;
            end
          end
        end
        sirp_pkg::I2C_MACK: begin
          if (clk_rise) begin
            if (sync_q.sda || bcnt_q == 2'd3) begin
              st_q <= sirp_pkg::I2C_SKIP;
            end else begin
              bcnt_q <= bcnt_q + 2'd1;
              st_q   <= sirp_pkg::I2C_RDAT;
            end
          end
        end
        default: st_q <= sirp_pkg::I2C_IDLE;
      endcase
    end
  end

  // ****************************************
  // Write arbitration and pin drive
  // ****************************************
  assign wr_en   = spi_wr | i2c_wr;
  assign wr_addr = spi_wr ? spi_hdr_q[6:1] : raddr_q;
  assign wr_data = spi_wr ? spi_sh_q : wbuf_q;

  // I2C only ever pulls low, never drives high, so no mastering
  assign miso_out  = mode_i2c_q ? 1'b0 : spi_miso_q;
  assign miso_oe_n = mode_i2c_q ? ~sda_low_q : ~sel_hi;

  // ****************************************
  // Checks
  // ****************************************
  a_miso_release: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!mode_i2c_q && !sel_hi) |-> miso_oe_n)
    else $error("MISO driven while select low");
  a_pulldown_mode: assert property (@(posedge sys_clk) disable iff (!nrst)
    sel_pulldown_en == !bus_mode_select_latch)
    else $error("pull-down not following mode");
  a_mode_stable: assert property (@(posedge sys_clk) disable iff (!nrst)
    !init_d1_q |-> $stable(mode_i2c_q))
    else $error("mode changed outside init");
  a_spi_commit: assert property (@(posedge sys_clk) disable iff (!nrst)
    spi_wr |=> regs_q[$past(spi_hdr_q[6:1])] == $past(spi_sh_q))
    else $error("SPI write not committed");
  a_read_nowr: assert property (@(posedge sys_clk) disable iff (!nrst)
    (spi_mode && !spi_hdr_q[7]) |-> !spi_wr)
    else $error("read frame wrote register");
  a_i2c_od: assert property (@(posedge sys_clk) disable iff (!nrst)
    mode_i2c_q |-> !miso_out)
    else $error("SDA driven high");
  a_i2c_third: assert property (@(posedge sys_clk) disable iff (!nrst)
    i2c_wr |-> bcnt_q == 2'd3 && !rnw_q)
    else $error("I2C commit before third byte");
  a_stop_abort: assert property (@(posedge sys_clk) disable iff (!nrst)
    i2c_stop |=> st_q == sirp_pkg::I2C_IDLE && !wr_en)
    else $error("stop did not abort");
  a_hdr_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
    (spi_mode && sel_hi && clk_fall && spi_cnt_q < sirp_pkg::SPI_LAST_HDR) |=> !spi_miso_q)
    else $error("header field not zero");
  a_reg_select: assert property (@(posedge sys_clk) disable iff (!nrst)
    (mode_i2c_q && !i2c_stop && !i2c_start && st_q == sirp_pkg::I2C_REG && clk_fall
     && bit_q == 4'd8) |=> raddr_q == $past(byte_q[5:0]))
    else $error("register byte not taken");

endmodule

`default_nettype wire

// ===== common/sirp_pkg.sv
// Package: constants and carrier types for the serial register port
package sirp_pkg;
  localparam int          FRAME_BITS     = 32;
  localparam int          ADDR_BITS      = 6;
  localparam int          DATA_BITS      = 24;
  localparam int          REG_COUNT      = 64;
  localparam logic [5:0]  SPI_LAST_HDR   = 6'h07;
  localparam logic [5:0]  SPI_LAST_BIT   = 6'h1f;
  localparam logic [5:0]  I2C_ADDR_HI    = 6'h04;
  localparam logic [23:0] REG_RST_VAL    = 24'h000000;
  localparam int          SYS_CLK_HZ     = 20000000;
  localparam int          I2C_MAX_KBPS   = 400;
  localparam int          I2C_BIT_CYC    = SYS_CLK_HZ / (I2C_MAX_KBPS * 1000);

  typedef struct packed {
    logic       clk;
    logic       sel;
    logic       mosi;
    logic       sda;
  } sirp_pins_s;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_DEV  = 3'b001,
    I2C_DACK = 3'b011,
    I2C_REG  = 3'b010,
    I2C_WDAT = 3'b110,
    I2C_RDAT = 3'b111,
    I2C_MACK = 3'b101,
    I2C_SKIP = 3'b100
  } sirp_i2c_e;
endpackage

// ===== tb/sirp_host.sv
// Host model: SPI and I2C master on the serial register port pins
`timescale 1ns/1ns
`default_nettype none
module sirp_host (
  // Pins
  output var logic sel,
  output var logic sclk,
  output var logic mosi,
  output var logic sda_oe_n,
  input  wire logic sda
);
  // Runs SCL right at the fast mode ceiling, 2500 ns per bit
  localparam int HB = 1250;
  initial begin
    sel = 1'b0;
    sclk = 1'b0;
    mosi = 1'b0;
    sda_oe_n = 1'b1;
  end
  task automatic strap(input logic s, input logic m);
    sel = s;
    mosi = m;
  endtask
  // A count below 32 drops select before the last falling edge
  task automatic spi(input logic wr, input logic [5:0] a, input logic [23:0] d,
                     input int n, output logic [31:0] q);
    logic [31:0] f;
    f = {wr, a, 1'b0, d};
    q = 32'h0;
    sel = 1'b1;
    #200;
    for (int i = 31; i > 31 - n; i--) begin
      mosi = f[i];
      #200 sclk = 1'b1;
      #190 q[i] = sda;
      #10 sclk = 1'b0;
    end
    #200 sel = 1'b0;
    mosi = ~mosi;
    #400;
  endtask
  // Releases the wire first so a repeated start also works
  task automatic i2c_start;
    sda_oe_n = 1'b1;
    #HB sclk = 1'b1;
    #HB sda_oe_n = 1'b0;
    #HB sclk = 1'b0;
  endtask
  task automatic i2c_stop;
    sda_oe_n = 1'b0;
    #HB sclk = 1'b1;
    #HB sda_oe_n = 1'b1;
    #HB;
  endtask
  // Open drain: a one releases the wire
  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_oe_n = b[i];
      #HB sclk = 1'b1;
      #HB sclk = 1'b0;
    end
    sda_oe_n = 1'b1;
    #HB sclk = 1'b1;
    #(HB - 10) ack = ~sda;
    #10 sclk = 1'b0;
  endtask
  // Master receive; a high nack ends the read
  task automatic i2c_rbyte(input logic nack, output logic [7:0] b);
    sda_oe_n = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      #HB sclk = 1'b1;
      #(HB - 10) b[i] = sda;
      #10 sclk = 1'b0;
    end
    sda_oe_n = nack;
    #HB sclk = 1'b1;
    #HB sclk = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Testbench: SPI register traffic and I2C addressing of the port
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        sys_clk;
  logic        nrst;
  logic        init_phase;
  logic        sel;
  logic        sclk;
  logic        mosi;
  logic        h_oe_n;
  logic        miso_out;
  logic        miso_oe_n;
  logic        pd_en;
  logic        mode;
  wire logic   sda;
  int          n_fail;
  int          cmp_count;
  logic [23:0] exp_q [64];
  logic [31:0] q;
  logic        ack;
  // Board pull-up on the data wire; either side may pull it low
  assign sda = (!miso_oe_n ? miso_out : 1'b1) & h_oe_n;
  sirp_port sirp_port_inst (.sys_clk(sys_clk), .nrst(nrst), .init_phase(init_phase),
    .sel_pin(sel), .clk_pin(sclk), .mosi_pin(mosi), .miso_in(sda), .miso_out(miso_out),
    .miso_oe_n(miso_oe_n), .sel_pulldown_en(pd_en), .bus_mode_select_latch(mode));
  sirp_host sirp_host_inst (.sel(sel), .sclk(sclk), .mosi(mosi), .sda_oe_n(h_oe_n),
    .sda(sda));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    cmp_count++;
    if (seen !== want) begin
      n_fail++;
      $display("BAD %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask
  task automatic final_report;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Strap the pins, reset, then open the mode latch
  task automatic boot(input logic s, input logic a0);
    sirp_host_inst.strap(s, a0);
    foreach (exp_q[i]) exp_q[i] = 24'h0;
    @(posedge sys_clk) nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    init_phase <= 1'b1;
    repeat (4) @(posedge sys_clk);
    init_phase <= 1'b0;
    repeat (5) @(posedge sys_clk);
  endtask
  task automatic spi_op(input logic wr, input logic [5:0] a, input logic [23:0] d,
                        input int n);
    // Pin changes start off the sampling edge of the system clock
    @(negedge sys_clk);
    sirp_host_inst.spi(wr, a, d, n, q);
    if (n == 32) check(q, {8'h00, exp_q[a]}, "spi read-back");
    check({31'h0, miso_oe_n}, 32'h1, "miso not released");
    if (wr && n == 32) exp_q[a] = d;
  endtask
  // n counts bytes after start: address, register, then data
  task automatic i2c_wr(input logic [5:0] a, input logic [23:0] d, input int n);
    logic [7:0] b [5];
    b = '{8'h12, {2'b00, a}, d[23:16], d[15:8], d[7:0]};
    @(negedge sys_clk);
    sirp_host_inst.i2c_start();
    for (int i = 0; i < n; i++) begin
      sirp_host_inst.i2c_byte(b[i], ack);
      check({31'h0, ack}, 32'h1, "write byte ack");
    end
    sirp_host_inst.i2c_stop();
    if (n == 5) exp_q[a] = d;
  endtask
  // Upper bits of the register byte set to show they are ignored
  task automatic i2c_rd(input logic [5:0] a);
    logic [7:0]  b;
    logic [23:0] r;
    @(negedge sys_clk);
    sirp_host_inst.i2c_start();
    sirp_host_inst.i2c_byte(8'h12, ack);
    check({31'h0, ack}, 32'h1, "read addr ack");
    sirp_host_inst.i2c_byte({2'b11, a}, ack);
    check({31'h0, ack}, 32'h1, "register byte ack");
    sirp_host_inst.i2c_start();
    sirp_host_inst.i2c_byte(8'h13, ack);
    check({31'h0, ack}, 32'h1, "read dir ack");
    for (int i = 2; i >= 0; i--) begin
      sirp_host_inst.i2c_rbyte(i == 0, b);
      r[i*8 +: 8] = b;
    end
    sirp_host_inst.i2c_stop();
    check({8'h00, r}, {8'h00, exp_q[a]}, "i2c read-back");
  endtask
  // ************************************
  // Scenarios
  // ************************************
  task automatic sc_spi_boot;
    boot(1'b0, 1'b0);
    check({30'h0, mode, pd_en}, 32'h1, "spi mode latch");
    check({31'h0, miso_oe_n}, 32'h1, "miso idle");
  endtask
  // Edge addresses back to back; rewrites return the old value
  task automatic sc_spi_rw;
    logic [5:0]  a [4] = '{6'h00, 6'h3f, 6'h15, 6'h3f};
    logic [23:0] d [4] = '{24'ha5c3f0, 24'h5a3c0f, 24'hffffff, 24'h000001};
    for (int i = 0; i < 4; i++) spi_op(1'b1, a[i], d[i], 32);
    for (int i = 0; i < 3; i++) spi_op(1'b0, a[i], 24'h0, 32);
  endtask
  task automatic sc_spi_read_keeps;
    spi_op(1'b0, 6'h15, 24'h123456, 32);
    spi_op(1'b0, 6'h15, 24'h000000, 32);
  endtask
  // Select dropped one edge short must not write
  task automatic sc_spi_abort;
    spi_op(1'b1, 6'h00, 24'h0f0f0f, 31);
    spi_op(1'b0, 6'h00, 24'h000000, 32);
  endtask
  task automatic sc_i2c_addr;
    logic [7:0] dev [3] = '{8'h12, 8'h10, 8'h00};
    boot(1'b1, 1'b1);
    check({30'h0, mode, pd_en}, 32'h2, "i2c mode latch");
    for (int i = 0; i < 3; i++) begin
      @(negedge sys_clk);
      sirp_host_inst.i2c_start();
      sirp_host_inst.i2c_byte(dev[i], ack);
      check({31'h0, ack}, {31'h0, i == 0}, "address ack");
      check({31'h0, miso_out & ~miso_oe_n}, 32'h0, "sda driven high");
      sirp_host_inst.i2c_stop();
      repeat (4) @(posedge sys_clk);
      check({31'h0, miso_oe_n}, 32'h1, "sda held after stop");
    end
  endtask
  // Full write and read back, then a write cut after two data bytes
  task automatic sc_i2c_rw;
    i2c_wr(6'h2a, 24'hc35a96, 5);
    i2c_rd(6'h2a);
    i2c_wr(6'h2a, 24'h0f1e2d, 4);
    i2c_rd(6'h2a);
  endtask
  initial begin
    #2000000;
    n_fail++;
    final_report();
  end
  initial begin
    nrst = 1'b0;
    init_phase = 1'b0;
    n_fail = 0;
    cmp_count = 0;
    sc_spi_boot();
    sc_spi_rw();
    sc_spi_read_keeps();
    sc_spi_abort();
    sc_i2c_addr();
    sc_i2c_rw();
    final_report();
  end
endmodule
`default_nettype wire
